// ### rtl/esl_pkg.sv
// Constants, opcodes and states of the settings loader
//
// Behaviour
// [RULE1] Upload writes one checksum byte after each data block's register bytes.
// [RULE2] Upload memory pointer advances by byte count plus one per block.
// [RULE3] Upload copies the pending value of double-buffered registers.
// [RULE4] Upload stores condition instructions unchanged, no conditional effect.
// [RULE5] Software load bit starts a download and is cleared by the loader.
// [RULE6] Download reads memory bytewise, executes until end, writes data bytes.
// [RULE7] After any reset a nonzero strap value starts a download as condition.
// [RULE8] Condition and end instructions always execute during download.
// [RULE9] Condition is five bits; zero executes everything.
// [RULE10] Nonzero register condition wins over strap condition.
// [RULE11] Codes B1 to CF tag conditions 1 to 31; several may be tagged.
// [RULE12] B0 clears the tag board; following instructions run unconditionally.
// [RULE13] Nonzero condition with tags: execute only while condition is tagged.
// [RULE14] Software stores setups as condition, data, pause; later ones start B0.
// [RULE15] Codes 00 to 7F are data: count is code plus one, two address bytes.
// [RULE16] Download: 80 I/O update, A0 calibration, A1 distribution sync.
// [RULE17] Download end code FF resets memory pointer and returns to idle.
// [RULE18] Download compares checksums; mismatch sets fault, all good sets complete.
// [RULE19] Checksum is mod-256 sum of code, address bytes and data bytes.
package esl_pkg;
  localparam int MEM_AW = 11;
  localparam int MEM_DEPTH = 2048;
  localparam int SP_AW = 6;
  localparam logic [SP_AW-1:0] SP_LAST = 6'h2f;
  localparam logic [7:0] OP_DATA_MAX = 8'h7f;
  localparam logic [7:0] OP_IOUPD = 8'h80;
  localparam logic [7:0] OP_CAL = 8'ha0;
  localparam logic [7:0] OP_SYNC = 8'ha1;
  localparam logic [7:0] OP_NULL = 8'hb0;
  localparam logic [7:0] OP_COND_MAX = 8'hcf;
  localparam logic [7:0] OP_PAUSE = 8'hfe;
  localparam logic [7:0] OP_END = 8'hff;
  localparam int COND_W = 5;
  localparam int STRAP_LO = 3;
  localparam int STRAP_HI = 7;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SP_RD, ST_SP_OP, ST_SP_A1, ST_SP_A2, ST_UP_RD, ST_UP_WR,
    ST_UP_CK, ST_DN_RD, ST_DN_OP, ST_DN_A1, ST_DN_A2, ST_DN_DAT, ST_DN_CK
  } esl_state_t;
endpackage

// ### rtl/esl_mem.sv
// Nonvolatile memory array model: one write port, registered read data
module esl_mem
(
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [esl_pkg::MEM_AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // Read port
  input wire logic [esl_pkg::MEM_AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_ff [esl_pkg::MEM_DEPTH];

  // ==========================================================
  // Storage; no reset so it maps onto a real array
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_ff[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_ff[raddr_i];
  end
endmodule

// ### rtl/esl_loader.sv
// Settings loader between nonvolatile memory and the register map
module esl_loader
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Software control
  input wire logic save_req_i,
  input wire logic load_req_i,
  input wire logic soft_reset_i,
  input wire logic [esl_pkg::COND_W-1:0] cond_reg_i,
  input wire logic [7:0] condition_strap_pins_i,
  output logic save_clr_o,
  output logic load_clr_o,
  output logic busy_o,
  output logic fault_o,
  output logic complete_o,
  // Scratch pad read
  output logic [esl_pkg::SP_AW-1:0] sp_addr_o,
  input wire logic [7:0] sp_data_i,
  // Register map read (pending value) and write
  output logic [15:0] map_raddr_o,
  input wire logic [7:0] map_pend_i,
  output logic map_wvalid_o,
  input wire logic map_wready_i,
  output logic [15:0] map_waddr_o,
  output logic [7:0] map_wdata_o,
  // Action pulses
  output logic io_update_o,
  output logic calibrate_o,
  output logic dist_sync_o
);
  esl_pkg::esl_state_t state_ff;
  logic [esl_pkg::MEM_AW-1:0] ptr_ff;
  logic [esl_pkg::SP_AW-1:0] sp_ff;
  logic [7:0] cnt_ff;
  logic [15:0] addr_ff;
  logic [7:0] sum_ff;
  logic [31:1] tags_ff;
  logic skip_ff;
  logic auto_ff;
  logic sr1_ff, sr2_ff, strap1_ff;
  logic [7:0] strap_m_ff, strap_ff;
  logic mem_we;
  logic [7:0] mem_wd, mem_rd;
  logic [esl_pkg::COND_W-1:0] cond;
  logic [1:0] buf_n_ff;
  logic [15:0] buf_a_ff [2];
  logic [7:0] buf_d_ff [2];
  logic buf_rdy, buf_push;
  logic [esl_pkg::MEM_AW-1:0] rd_a_ff;
  logic mem_ok;

  // ==========================================================
  // Memory
  esl_mem u_mem
  (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(ptr_ff),
    .wdata_i(mem_wd),
    .raddr_i(ptr_ff),
    .rdata_o(mem_rd)
  );

  function automatic logic is_cond(input logic [7:0] op);
    is_cond = (op >= esl_pkg::OP_NULL) && (op <= esl_pkg::OP_COND_MAX);
  endfunction

  // Condition number of a condition code, counted from the null code
  function automatic logic [esl_pkg::COND_W-1:0] cond_num(
    input logic [7:0] op);
    logic [7:0] rel;
    rel = op - esl_pkg::OP_NULL;
    cond_num = rel[esl_pkg::COND_W-1:0];
  endfunction

  // Address behind the registered read data; the array answers one clock
  // late, so a step that has just moved the pointer waits one cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_a_ff <= '0;
    end
    else
    begin
      rd_a_ff <= ptr_ff;
    end
  end
  assign mem_ok = (rd_a_ff == ptr_ff);

  // ==========================================================
  // Strap pins are asynchronous; two stages before use
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strap_m_ff <= 8'h00;
      strap_ff <= 8'h00;
      sr1_ff <= 1'b0;
      sr2_ff <= 1'b0;
    end
    else
    begin
      strap_m_ff <= condition_strap_pins_i;
      strap_ff <= strap_m_ff;
      sr1_ff <= soft_reset_i;
      sr2_ff <= sr1_ff;
    end
  end

  // Latch power-up condition at reset release or soft reset
  logic [esl_pkg::COND_W-1:0] power_up_pin_condition_ff;
  // Third edge after release: the strap value has crossed both stages
  logic [2:0] arm_ff;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      arm_ff <= 3'h0;
      power_up_pin_condition_ff <= 5'h00;
      auto_ff <= 1'b0;
    end
    else
    begin
      arm_ff <= {arm_ff[1:0], 1'b1};
      auto_ff <= 1'b0;
      if ((arm_ff == 3'h3) || (sr2_ff && !strap1_ff))
      begin
        power_up_pin_condition_ff <=
          strap_ff[esl_pkg::STRAP_HI:esl_pkg::STRAP_LO];
        auto_ff <= (strap_ff[esl_pkg::STRAP_HI:esl_pkg::STRAP_LO] != 5'h00); // [RULE7]
      end
    end
  end

  // Soft reset edge memory
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strap1_ff <= 1'b0;
    end
    else
    begin
      strap1_ff <= sr2_ff;
    end
  end

  // Register field wins when nonzero
  assign cond = (cond_reg_i != 5'h00) ? cond_reg_i
                                      : power_up_pin_condition_ff; // [RULE10]

  // ==========================================================
  // Two-entry write buffer toward the register map; a stall loses nothing
  assign buf_rdy = (buf_n_ff != 2'h2);
  assign buf_push = (state_ff == esl_pkg::ST_DN_DAT) && mem_ok &&
                    buf_rdy && !skip_ff;
  assign map_wvalid_o = (buf_n_ff != 2'h0);
  assign map_waddr_o = buf_a_ff[0];
  assign map_wdata_o = buf_d_ff[0];
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      buf_n_ff <= 2'h0;
      buf_a_ff[0] <= 16'h0000;
      buf_a_ff[1] <= 16'h0000;
      buf_d_ff[0] <= 8'h00;
      buf_d_ff[1] <= 8'h00;
    end
    else
    begin
      if (map_wvalid_o && map_wready_i)
      begin
        buf_a_ff[0] <= buf_a_ff[1];
        buf_d_ff[0] <= buf_d_ff[1];
      end
      if (buf_push)
      begin
        if ((buf_n_ff == 2'h0) ||
            ((buf_n_ff == 2'h1) && map_wready_i))
        begin
          buf_a_ff[0] <= addr_ff;
          buf_d_ff[0] <= mem_rd;
        end
        else
        begin
          buf_a_ff[1] <= addr_ff;
          buf_d_ff[1] <= mem_rd;
        end
      end
      buf_n_ff <= buf_n_ff + {1'b0, buf_push}
                  - {1'b0, map_wvalid_o && map_wready_i};
    end
  end

  // ==========================================================
  // Memory write data: checksum byte or copied byte
  always_comb
  begin
    mem_we = 1'b0;
    mem_wd = sp_data_i;
    unique case (state_ff)
      // End code is stored too, or a download would run past the program
      esl_pkg::ST_SP_OP: mem_we = (sp_data_i != esl_pkg::OP_PAUSE); // [RULE4]
      esl_pkg::ST_SP_A1, esl_pkg::ST_SP_A2: mem_we = 1'b1;
      esl_pkg::ST_UP_WR:
      begin
        mem_we = 1'b1;
        mem_wd = map_pend_i; // [RULE3]
      end
      esl_pkg::ST_UP_CK:
      begin
        mem_we = 1'b1;
        mem_wd = sum_ff; // [RULE1]
      end
      default: mem_we = 1'b0;
    endcase
  end

  assign sp_addr_o = sp_ff;
  assign map_raddr_o = addr_ff;
  assign busy_o = (state_ff != esl_pkg::ST_IDLE);

  // ==========================================================
  // Main sequencer: one byte per step, pointer follows every byte
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= esl_pkg::ST_IDLE;
      ptr_ff <= '0;
      sp_ff <= '0;
      cnt_ff <= 8'h00;
      addr_ff <= 16'h0000;
      sum_ff <= 8'h00;
      tags_ff <= '0;
      skip_ff <= 1'b0;
      fault_o <= 1'b0;
      complete_o <= 1'b0;
      save_clr_o <= 1'b0;
      load_clr_o <= 1'b0;
      io_update_o <= 1'b0;
      calibrate_o <= 1'b0;
      dist_sync_o <= 1'b0;
    end
    else
    begin
      save_clr_o <= 1'b0;
      load_clr_o <= 1'b0;
      io_update_o <= 1'b0;
      calibrate_o <= 1'b0;
      dist_sync_o <= 1'b0;
      unique case (state_ff)
        esl_pkg::ST_IDLE:
        begin
          if (load_req_i || auto_ff)
          begin
            load_clr_o <= load_req_i; // [RULE5]
            ptr_ff <= '0;
            tags_ff <= '0;
            skip_ff <= 1'b0;
            fault_o <= 1'b0;
            complete_o <= 1'b0;
            state_ff <= esl_pkg::ST_DN_RD;
          end
          else if (save_req_i)
          begin
            save_clr_o <= 1'b1;
            sp_ff <= '0;
            state_ff <= esl_pkg::ST_SP_OP;
          end
        end
        // Upload: scratch pad is combinational read
        esl_pkg::ST_SP_OP:
        begin
          sp_ff <= sp_ff + 6'h01;
          sum_ff <= sp_data_i;
          cnt_ff <= sp_data_i;
          if (sp_data_i == esl_pkg::OP_END)
          begin
            ptr_ff <= '0;
            state_ff <= esl_pkg::ST_IDLE;
          end
          else if (sp_data_i == esl_pkg::OP_PAUSE || sp_ff == esl_pkg::SP_LAST)
          begin
            state_ff <= esl_pkg::ST_IDLE;
          end
          else
          begin
            ptr_ff <= ptr_ff + 11'h001;
            if (sp_data_i <= esl_pkg::OP_DATA_MAX)
            begin
              state_ff <= esl_pkg::ST_SP_A1; // [RULE15]
            end
          end
        end
        esl_pkg::ST_SP_A1:
        begin
          sp_ff <= sp_ff + 6'h01;
          ptr_ff <= ptr_ff + 11'h001;
          addr_ff[15:8] <= sp_data_i;
          sum_ff <= sum_ff + sp_data_i; // [RULE19]
          state_ff <= esl_pkg::ST_SP_A2;
        end
        esl_pkg::ST_SP_A2:
        begin
          sp_ff <= sp_ff + 6'h01;
          ptr_ff <= ptr_ff + 11'h001;
          addr_ff[7:0] <= sp_data_i;
          sum_ff <= sum_ff + sp_data_i; // [RULE19]
          state_ff <= esl_pkg::ST_UP_WR;
        end
        esl_pkg::ST_UP_WR:
        begin
          ptr_ff <= ptr_ff + 11'h001;
          addr_ff <= addr_ff + 16'h0001;
          sum_ff <= sum_ff + map_pend_i; // [RULE19]
          cnt_ff <= cnt_ff - 8'h01;
          if (cnt_ff == 8'h00)
          begin
            state_ff <= esl_pkg::ST_UP_CK;
          end
        end
        esl_pkg::ST_UP_CK:
        begin
          ptr_ff <= ptr_ff + 11'h001; // [RULE2]
          state_ff <= esl_pkg::ST_SP_OP;
        end
        // Download: memory read data arrive one cycle after the pointer
        esl_pkg::ST_DN_RD:
        begin
          state_ff <= esl_pkg::ST_DN_OP;
        end
        // Every download step except ST_DN_RD waits until the read data match the pointer
        esl_pkg::ST_DN_OP:
        begin
          if (mem_ok)
          begin
            ptr_ff <= ptr_ff + 11'h001; // [RULE6]
            sum_ff <= mem_rd;
            cnt_ff <= mem_rd;
            state_ff <= esl_pkg::ST_DN_RD;
            if (mem_rd == esl_pkg::OP_END)
            begin
              ptr_ff <= '0; // [RULE17]
              complete_o <= !fault_o; // [RULE18]
              state_ff <= esl_pkg::ST_IDLE; // [RULE8]
            end
            else if (is_cond(mem_rd))
            begin
              if (mem_rd == esl_pkg::OP_NULL)
              begin
                tags_ff <= '0; // [RULE12]
                skip_ff <= 1'b0;
              end
              else
              begin
                tags_ff[cond_num(mem_rd)] <= 1'b1; // [RULE11]
                skip_ff <= (cond != 5'h00) && !tags_ff[cond] &&
                           (cond_num(mem_rd) != cond); // [RULE13]
              end
            end
            else if (mem_rd <= esl_pkg::OP_DATA_MAX)
            begin
              state_ff <= esl_pkg::ST_DN_A1; // [RULE15]
            end
            else if (!skip_ff) // [RULE9]
            begin
              io_update_o <= (mem_rd == esl_pkg::OP_IOUPD); // [RULE16]
              calibrate_o <= (mem_rd == esl_pkg::OP_CAL);
              dist_sync_o <= (mem_rd == esl_pkg::OP_SYNC);
            end
          end
        end
        // Address high byte first, then low byte
        esl_pkg::ST_DN_A1:
        begin
          if (mem_ok)
          begin
            ptr_ff <= ptr_ff + 11'h001;
            addr_ff[15:8] <= mem_rd;
            sum_ff <= sum_ff + mem_rd; // [RULE19]
            state_ff <= esl_pkg::ST_DN_A2;
          end
        end
        esl_pkg::ST_DN_A2:
        begin
          if (mem_ok)
          begin
            ptr_ff <= ptr_ff + 11'h001;
            addr_ff[7:0] <= mem_rd;
            sum_ff <= sum_ff + mem_rd; // [RULE19]
            state_ff <= esl_pkg::ST_DN_DAT;
          end
        end
        // Skipped blocks still walk their bytes so the checksum is checked
        esl_pkg::ST_DN_DAT:
        begin
          if (mem_ok && (buf_rdy || skip_ff))
          begin
            ptr_ff <= ptr_ff + 11'h001;
            sum_ff <= sum_ff + mem_rd; // [RULE19]
            cnt_ff <= cnt_ff - 8'h01;
            addr_ff <= addr_ff + 16'h0001;
            if (cnt_ff == 8'h00)
            begin
              state_ff <= esl_pkg::ST_DN_CK;
            end
          end
        end
        esl_pkg::ST_DN_CK:
        begin
          if (mem_ok)
          begin
            if (mem_rd != sum_ff)
            begin
              fault_o <= 1'b1; // [RULE18]
            end
            ptr_ff <= ptr_ff + 11'h001;
            state_ff <= esl_pkg::ST_DN_RD;
          end
        end
        default: state_ff <= esl_pkg::ST_IDLE;
      endcase
    end
  end
endmodule

// ### dv/esl_loader_assertions.sv
// Concurrent checks on the settings loader ports
module esl_loader_chk
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control and status
  input wire logic load_req_i,
  input wire logic load_clr_o,
  input wire logic save_clr_o,
  input wire logic busy_o,
  input wire logic fault_o,
  input wire logic complete_o,
  // Register map write
  input wire logic map_wvalid_o,
  input wire logic map_wready_i,
  input wire logic [15:0] map_waddr_o,
  input wire logic [7:0] map_wdata_o,
  // Action pulses
  input wire logic io_update_o,
  input wire logic calibrate_o,
  input wire logic dist_sync_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so one default clock and reset
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Properties
  property p_load_take;
    load_req_i && !busy_o |-> ##[1:2] load_clr_o;
  endproperty
  property p_clr_one;
    (load_clr_o || save_clr_o) |=> !(load_clr_o || save_clr_o);
  endproperty
  // A stalled word must not change, or the map sees a torn write
  property p_wr_hold;
    map_wvalid_o && !map_wready_i |=>
      map_wvalid_o && $stable(map_waddr_o) && $stable(map_wdata_o);
  endproperty
  property p_fc_excl;
    !(fault_o && complete_o);
  endproperty
  property p_fc_clear;
    $fell(complete_o) |-> busy_o;
  endproperty
  property p_act_one;
    $onehot0({io_update_o, calibrate_o, dist_sync_o});
  endproperty
  property p_act_pulse;
    (io_update_o || calibrate_o || dist_sync_o) |=>
      !(io_update_o || calibrate_o || dist_sync_o);
  endproperty
  // Bound suits the short programs of the bench only
  property p_busy_end;
    $rose(busy_o) |-> ##[1:1000] !busy_o;
  endproperty
  // ==========================================================
  // Assertions and covers
  a_load_take: assert property (p_load_take) else $error("load lost");
  a_clr_one: assert property (p_clr_one) else $error("clear long");
  a_wr_hold: assert property (p_wr_hold) else $error("write moved");
  a_fc_excl: assert property (p_fc_excl) else $error("fault and ok");
  a_fc_clear: assert property (p_fc_clear) else $error("ok dropped");
  a_act_one: assert property (p_act_one) else $error("two actions");
  a_act_pulse: assert property (p_act_pulse) else $error("long act");
  a_busy_end: assert property (p_busy_end) else $error("no end");
  c_done: cover property ($rose(complete_o));
  c_stall: cover property (map_wvalid_o && !map_wready_i);
  c_sync: cover property (dist_sync_o);
endmodule

bind esl_loader esl_loader_chk u_chk
(
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .load_req_i(load_req_i),
  .load_clr_o(load_clr_o),
  .save_clr_o(save_clr_o),
  .busy_o(busy_o),
  .fault_o(fault_o),
  .complete_o(complete_o),
  .map_wvalid_o(map_wvalid_o),
  .map_wready_i(map_wready_i),
  .map_waddr_o(map_waddr_o),
  .map_wdata_o(map_wdata_o),
  .io_update_o(io_update_o),
  .calibrate_o(calibrate_o),
  .dist_sync_o(dist_sync_o)
);

// ### dv/esl_far_model.sv
// Far-side model: scratch pad, pending register values, write sink
module esl_far_model
(
  // Clock and stall control
  input wire logic clk_i,
  input wire logic slow_i,
  // Scratch pad read
  input wire logic [esl_pkg::SP_AW-1:0] sp_addr_i,
  output logic [7:0] sp_data_o,
  // Register map
  input wire logic [15:0] map_raddr_i,
  output logic [7:0] map_pend_o,
  input wire logic map_wvalid_i,
  output logic map_wready_o,
  input wire logic [15:0] map_waddr_i,
  input wire logic [7:0] map_wdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sp [64];
  logic [95:0] prog = 96'hb1010010_b080a0a1_000020ff;
  logic [1:0] cnt = 2'h0;
  logic [23:0] wlog [$];
  // ==========================================================
  // Program: one tagged block, clear, actions, open block, end
  initial
  begin
    foreach (sp[i]) sp[i] = 8'hff;
    for (int i = 0; i < 12; i++) sp[i] = prog[95-8*i -: 8];
  end
  // Pending copy differs from address so a wrong source shows
  assign sp_data_o = sp[sp_addr_i];
  assign map_pend_o = map_raddr_i[7:0] ^ 8'h5a;
  // Slow mode accepts one word in four to fill the buffer
  assign map_wready_o = !slow_i || cnt == 2'h3;
  // Log every accepted write; plain always since the bench clears the log
  always @(posedge clk_i)
  begin
    cnt <= cnt + 2'h1;
    if (map_wvalid_i && map_wready_o)
      wlog.push_back({map_waddr_i, map_wdata_i});
  end
endmodule

// ### dv/tb.sv
// Self-checking bench of the settings loader
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_n_i, save_req_i, load_req_i, soft_reset_i, slow;
  logic [4:0] cond_reg_i;
  logic [7:0] strap, sp_data, pend, wdata;
  logic [5:0] sp_addr;
  logic [15:0] raddr, waddr;
  logic save_clr, load_clr, busy, fault, complete, wvalid, wready;
  logic io_upd, cal, sync;
  int mismatches, total_checks, cyc, n_io, n_cal, n_sync;
  localparam logic [71:0] ALL = {24'h00207a, 24'h00114b, 24'h00104a};
  localparam logic [71:0] LAST = {48'h0, 24'h00207a};

  esl_loader DUT
  (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .save_req_i(save_req_i),
    .load_req_i(load_req_i), .soft_reset_i(soft_reset_i),
    .cond_reg_i(cond_reg_i), .condition_strap_pins_i(strap),
    .save_clr_o(save_clr), .load_clr_o(load_clr), .busy_o(busy),
    .fault_o(fault), .complete_o(complete), .sp_addr_o(sp_addr),
    .sp_data_i(sp_data), .map_raddr_o(raddr), .map_pend_i(pend),
    .map_wvalid_o(wvalid), .map_wready_i(wready), .map_waddr_o(waddr),
    .map_wdata_o(wdata), .io_update_o(io_upd), .calibrate_o(cal),
    .dist_sync_o(sync)
  );
  esl_far_model u_far
  (
    .clk_i(clk_i), .slow_i(slow), .sp_addr_i(sp_addr),
    .sp_data_o(sp_data), .map_raddr_i(raddr), .map_pend_o(pend),
    .map_wvalid_i(wvalid), .map_wready_o(wready),
    .map_waddr_i(waddr), .map_wdata_i(wdata)
  );
  // ==========================================================
  // Clock, action counters and hang guard
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    n_io += io_upd;
    n_cal += cal;
    n_sync += sync;
    if (cyc == 20000)
    begin
      mismatches++;
      results();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
  endtask
  // Waits for idle with the write buffer drained
  task automatic settle();
    int k;
    k = 0;
    while ((busy || wvalid) && k < 2000)
    begin
      @(negedge clk_i);
      k++;
    end
    chk(24'h1, {23'h0, k < 2000});
  endtask
  task automatic req(input bit sv);
    int k;
    @(negedge clk_i);
    u_far.wlog.delete();
    {n_io, n_cal, n_sync} = '0;
    if (sv) save_req_i = 1'b1;
    else load_req_i = 1'b1;
    k = 0;
    while (!(sv ? save_clr : load_clr) && k < 20)
    begin
      @(negedge clk_i);
      k++;
    end
    chk(24'h1, {23'h0, k < 20});
    save_req_i = 1'b0;
    load_req_i = 1'b0;
    settle();
  endtask
  task automatic judge(input int n, input logic [71:0] ew);
    chk(24'(n), 24'(u_far.wlog.size()));
    for (int i = 0; i < n; i++) chk(ew[24*i +: 24], u_far.wlog[i]);
    chk(24'h010101, {8'(n_io), 8'(n_cal), 8'(n_sync)});
    chk(24'h1, {22'h0, fault, complete});
  endtask
  task automatic dl(input logic [4:0] c, input int n, input logic [71:0] ew);
    cond_reg_i = c;
    req(1'b0);
    judge(n, ew);
  endtask
  task automatic auto_run();
    int k;
    u_far.wlog.delete();
    {n_io, n_cal, n_sync} = '0;
    k = 0;
    while (!busy && k < 20)
    begin
      @(negedge clk_i);
      k++;
    end
    chk(24'h1, {23'h0, k < 20});
    settle();
    judge(1, LAST);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_upload();
    slow = 1'b0;
    req(1'b1);
    chk(24'h0, 24'(u_far.wlog.size()));
    $display("upload test done");
  endtask
  // Stalled sink; blocks read back right only if checksums were spaced
  task automatic t_plain();
    slow = 1'b1;
    dl(5'h00, 3, ALL);
    $display("plain download test done");
  endtask
  task automatic t_tags();
    dl(5'h02, 1, LAST);
    dl(5'h01, 3, ALL);
    $display("tag test done");
  endtask
  task automatic t_auto();
    cond_reg_i = 5'h00;
    strap = 8'h10;
    do_reset();
    auto_run();
    soft_reset_i = 1'b1;
    auto_run();
    soft_reset_i = 1'b0;
    dl(5'h01, 3, ALL);
    $display("auto download test done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {rst_n_i, save_req_i, load_req_i, soft_reset_i, slow} = '0;
    cond_reg_i = 5'h00;
    strap = 8'h00;
    {mismatches, total_checks, cyc, n_io, n_cal, n_sync} = '0;
    do_reset();
    repeat (8) @(negedge clk_i);
    t_upload();
    t_plain();
    t_tags();
    t_auto();
    results();
  end
endmodule
